// File: include/fts_mem_if.sv
/*
 * Interface between the port control logic and its storage array.
 * Assumes one clock shared by both ends; write is one cycle wide.
 */
`timescale 1ns/1ps
`include "fts_regs.svh"

interface fts_mem_if;
   logic [`FTS_ADDR_W-1:0] addr;
   logic                   we;
   logic [`FTS_LANES-1:0]  lane_we;
   logic [`FTS_WORD_W-1:0] wdata;
   logic [`FTS_WORD_W-1:0] rdata;

   modport ctrl (output addr, output we, output lane_we,
                 output wdata, input rdata);
   modport mem  (input addr, input we, input lane_we,
                 input wdata, output rdata);
endinterface : fts_mem_if

// File: include/fts_pkg.sv
/*
 * Types shared by the flow-through burst SRAM port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fts_pkg;

   // ==========================================================
   // data phase that follows an accepted edge
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_READ,
      PH_WRITE
   } fts_phase_e;

endpackage : fts_pkg

// File: include/fts_regs.svh
/*
 * Constants for the flow-through burst SRAM port: array geometry, lane
 * layout, APB register offsets, field positions and reset values.
 * Assumes inclusion by bare name from the port and array sources.
 */
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH

// ==========================================================
// array geometry
`define FTS_ADDR_W      18
`define FTS_DEPTH       262144
`define FTS_DATA_W      16
`define FTS_PAR_W       2
`define FTS_WORD_W      18
`define FTS_LANES       2
`define FTS_LANE_W      9
`define FTS_BURST_W     2

// ==========================================================
// register map (byte addresses)
`define FTS_APB_AW      12
`define FTS_OFS_CTRL    12'h000
`define FTS_OFS_STATUS  12'h004
`define FTS_OFS_ADDR    12'h008
`define FTS_OFS_COUNT   12'h00C

// ==========================================================
// fields and reset values
`define FTS_CTRL_EN_BIT      0
`define FTS_CTRL_RESET       1'h1
`define FTS_ST_SEL_BIT       0
`define FTS_ST_ORDER_BIT     1
`define FTS_ST_WRITE_BIT     2
`define FTS_ST_DRIVE_BIT     3
`define FTS_COUNT_W          16

`endif

// File: logic/fts_mem_array.sv
/*
 * Storage array of the SRAM port: one bank per byte lane, each lane
 * nine bits (eight data plus one parity), combinational read.
 * Assumes address and lane enables are stable around the write edge.
 */
`timescale 1ns/1ps
`include "fts_regs.svh"

module fts_mem_array
   import fts_pkg::*;
(
   input wire logic pclk,
   fts_mem_if.mem   mem
);

   // ==========================================================
   // per-lane banks
   genvar g;
   generate
      for (g = 0; g < `FTS_LANES; g = g + 1) begin : g_lane
         logic [`FTS_LANE_W-1:0] bank [0:`FTS_DEPTH-1];

         // only lanes enabled high on the bus get written
         always_ff @(posedge pclk) begin
            if (mem.we && mem.lane_we[g]) begin
               bank[mem.addr] <= mem.wdata[g*`FTS_LANE_W +: `FTS_LANE_W];
            end
         end

         // flow-through: no output register stage
         assign mem.rdata[g*`FTS_LANE_W +: `FTS_LANE_W] = bank[mem.addr];
      end
   endgenerate

endmodule : fts_mem_array

// File: logic/fts_sram_port.sv
/*
 * Flow-through burst SRAM port with zero turnaround, plus a small APB
 * slave for enable, status and an access counter.
 * Assumes all pin inputs are synchronous to pclk; the bus wire level
 * is resolved outside from data_oe and parity_oe.
 */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fts_regs.svh"

// Behaviour
// RULE1 - every synchronous input is registered on the rising clock edge
// RULE2 - clk_qualify_n high freezes all state; edges are ignored; here the strap capture and apb registers still update
// RULE3 - reads and writes mix freely, one word every enabled clock
// RULE4 - writes complete internally; no external write strobe needed
// RULE5 - drivers go high impedance during every write data phase
// RULE6 - 18-bit address sampled on the edge picks one of 262144 words
// RULE7 - words are 18 bits on one shared read/write bus
// RULE8 - lane 0 writes bits 7:0 and parity 0; lane 1 bits 15:8, parity 1
// RULE9 - write_request_n low starts a write; sampled on enabled edges
// RULE10 - advance_or_load high steps the burst counter
// RULE11 - advance_or_load low loads the external address
// RULE12 - master loads a fresh address first after being deselected
// RULE13 - burst order linear or interleaved, fixed by the strap
// RULE14 - selects sampled on clock; output enable gates drivers directly
// RULE15 - selected only with both low selects low and high select high
// RULE16 - reads show the location addressed at the previous enabled edge
// RULE17 - high impedance while deselected and first clock after it
// RULE18 - strap high means interleaved, low means linear
// RULE19 - burst modifies two low bits; count up or xor with start
// RULE20 - write data captured one enabled edge after its address
module fts_sram_port
   import fts_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`FTS_APB_AW-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     clk_qualify_n,
   input  wire logic [`FTS_ADDR_W-1:0]   address,
   input  wire logic                     write_request_n,
   input  wire logic [`FTS_LANES-1:0]    byte_lane_write_n,
   input  wire logic                     advance_or_load,
   input  wire logic                     select_low_a,
   input  wire logic                     select_high,
   input  wire logic                     select_low_b,
   input  wire logic                     out_drive_en_n,
   input  wire logic                     burst_order_strap,
   input  wire logic [`FTS_DATA_W-1:0]   data_in,
   output logic      [`FTS_DATA_W-1:0]   data_out,
   output logic      [`FTS_DATA_W-1:0]   data_oe,
   input  wire logic [`FTS_PAR_W-1:0]    parity_in,
   output logic      [`FTS_PAR_W-1:0]    parity_out,
   output logic      [`FTS_PAR_W-1:0]    parity_oe
);

   // ==========================================================
   // declarations
   logic                        clk_on;
   logic                        select_now;
   logic                        port_en_reg;
   logic                        interleaved_reg;
   logic                        strap_taken_reg;
   fts_phase_e                  phase_reg;
   fts_phase_e                  phase_next;
   logic [`FTS_ADDR_W-1:0]      addr_reg;
   logic [`FTS_ADDR_W-1:0]      addr_next;
   logic [`FTS_BURST_W-1:0]     start_reg;
   logic [`FTS_BURST_W-1:0]     count_reg;
   logic [`FTS_BURST_W-1:0]     count_next;
   logic [`FTS_LANES-1:0]       lanes_reg;
   logic                        was_sel_reg;
   logic                        drive_ok;
   logic                        drive_on;
   logic [`FTS_COUNT_W-1:0]     xfer_count_reg;
   logic                        apb_setup;
   logic                        apb_access;
   logic                        apb_hit;
   logic [31:0]                 rd_value;

   fts_mem_if mem_bus ();

   // ==========================================================
   // clock qualification and selection
   // one qualifier gates the port state updates below; strap capture and apb registers ignore it
   assign clk_on = ~clk_qualify_n;                          // [RULE2]

   // software can park the port as if deselected
   assign select_now = ~select_low_a & select_high          // [RULE15]
                     & ~select_low_b & port_en_reg;         // [RULE14]

   // ==========================================================
   // burst order strap
   // caught once after reset release; the strap must stay put
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interleaved_reg <= 1'b1;
         strap_taken_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
         interleaved_reg <= burst_order_strap;              // [RULE18]
         strap_taken_reg <= 1'b1;
      end
   end

   // ==========================================================
   // address and burst counter
   always_comb begin
      count_next = count_reg;
      addr_next  = addr_reg;
      if (advance_or_load) begin                            // [RULE10]
         count_next = count_reg + 2'h1;
         addr_next[`FTS_ADDR_W-1:`FTS_BURST_W] =
            addr_reg[`FTS_ADDR_W-1:`FTS_BURST_W];
         // wrap inside a four-word group
         if (interleaved_reg) begin                         // [RULE13]
            addr_next[`FTS_BURST_W-1:0] = start_reg ^ count_next; // [RULE19]
         end else begin
            addr_next[`FTS_BURST_W-1:0] = start_reg + count_next; // [RULE19]
         end
      end else begin
         count_next = 2'h0;
         addr_next  = address;                              // [RULE11]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg  <= 18'h00000;
         start_reg <= 2'h0;
         count_reg <= 2'h0;
      end else if (clk_on && select_now) begin              // [RULE1]
         addr_reg  <= addr_next;                            // [RULE6]
         count_reg <= count_next;
         if (!advance_or_load) begin
            start_reg <= address[`FTS_BURST_W-1:0];
         end
      end
   end

   // ==========================================================
   // control capture and data phase
   always_comb begin
      if (!select_now) begin
         phase_next = PH_IDLE;
      end else if (!write_request_n) begin                  // [RULE9]
         phase_next = PH_WRITE;
      end else begin
         phase_next = PH_READ;
      end
   end

   // reads and writes follow each other with no idle cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg   <= PH_IDLE;
         lanes_reg   <= 2'h3;
         was_sel_reg <= 1'b0;
      end else if (clk_on) begin                            // [RULE1] [RULE3]
         phase_reg   <= phase_next;
         lanes_reg   <= byte_lane_write_n;
         was_sel_reg <= select_now;
      end
   end

   // ==========================================================
   // write path
   // the data arrive one enabled edge after the address, so the
   // address register still holds the target at that edge
   assign mem_bus.addr    = addr_reg;
   assign mem_bus.we      = clk_on && (phase_reg == PH_WRITE); // [RULE20]
   assign mem_bus.lane_we = ~lanes_reg;                     // [RULE8]

   // lane i word slice is {parity i, data byte i}
   genvar g;
   generate
      for (g = 0; g < `FTS_LANES; g = g + 1) begin : g_pack
         assign mem_bus.wdata[g*`FTS_LANE_W +: `FTS_LANE_W] =
            {parity_in[g], data_in[g*8 +: 8]};              // [RULE7]
      end
   endgenerate

   // write completes inside the array on the qualified edge
   fts_mem_array u_array (                                  // [RULE4]
      .pclk (pclk),
      .mem  (mem_bus)
   );

   // ==========================================================
   // read path and drivers
   // drive only in a read data phase that is not the first
   // clock after a deselected edge
   assign drive_ok = (phase_reg == PH_READ) && was_sel_reg; // [RULE5] [RULE17]

   // tracks whether the accepted edge before the last one was a selected one
   logic prev_sel_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_sel_reg <= 1'b0;
      end else if (clk_on) begin
         prev_sel_reg <= was_sel_reg;
      end
   end

   // the output enable pin gates the drivers with no clock
   assign drive_on = drive_ok && prev_sel_reg
                   && !out_drive_en_n;                      // [RULE14]

   generate
      for (g = 0; g < `FTS_LANES; g = g + 1) begin : g_out
         assign data_out[g*8 +: 8] =
            mem_bus.rdata[g*`FTS_LANE_W +: 8];              // [RULE16]
         assign parity_out[g] =
            mem_bus.rdata[g*`FTS_LANE_W + 8];
         assign data_oe[g*8 +: 8] = {8{drive_on}};
         assign parity_oe[g]      = drive_on;
      end
   endgenerate

   // ==========================================================
   // access counter
   // counts data phases; wraps silently at the top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_count_reg <= 16'h0000;
      end else if (apb_access && pwrite
                   && paddr == `FTS_OFS_COUNT) begin
         xfer_count_reg <= 16'h0000;
      end else if (clk_on && phase_reg != PH_IDLE) begin
         xfer_count_reg <= xfer_count_reg + 16'h0001;
      end
   end

   // ==========================================================
   // apb slave
   assign apb_setup  = psel && !penable;
   assign apb_access = psel && penable;
   assign pready     = 1'b1;

   always_comb begin
      apb_hit  = 1'b1;
      rd_value = 32'h00000000;
      if (paddr == `FTS_OFS_CTRL) begin
         rd_value[`FTS_CTRL_EN_BIT] = port_en_reg;
      end else if (paddr == `FTS_OFS_STATUS) begin
         rd_value[`FTS_ST_SEL_BIT]   = was_sel_reg;
         rd_value[`FTS_ST_ORDER_BIT] = interleaved_reg;
         rd_value[`FTS_ST_WRITE_BIT] = (phase_reg == PH_WRITE);
         rd_value[`FTS_ST_DRIVE_BIT] = drive_on;
      end else if (paddr == `FTS_OFS_ADDR) begin
         rd_value[`FTS_ADDR_W-1:0] = addr_reg;
      end else if (paddr == `FTS_OFS_COUNT) begin
         rd_value[`FTS_COUNT_W-1:0] = xfer_count_reg;
      end else begin
         apb_hit = 1'b0;
      end
   end

   assign pslverr = apb_access && !apb_hit;

   // read data is latched in setup so it stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_setup && !pwrite) begin
         prdata <= rd_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_en_reg <= `FTS_CTRL_RESET;
      end else if (apb_access && pwrite
                   && paddr == `FTS_OFS_CTRL) begin
         port_en_reg <= pwdata[`FTS_CTRL_EN_BIT];
      end
   end

endmodule : fts_sram_port

// File: tb/fts_bus_model.sv
/* Controller side of the shared data bus: resolves the wire level.
   Assumes the bench says when the controller drives write data. */
`timescale 1ns/1ps
`include "fts_regs.svh"
module fts_bus_model (
   input wire logic                   pclk,
   input wire logic                   m_en,
   input wire logic [`FTS_WORD_W-1:0] m_word,
   input wire logic [`FTS_DATA_W-1:0] data_out,
   input wire logic [`FTS_DATA_W-1:0] data_oe,
   input wire logic [`FTS_PAR_W-1:0]  parity_out,
   input wire logic [`FTS_PAR_W-1:0]  parity_oe,
   output logic     [`FTS_DATA_W-1:0] data_in,
   output logic     [`FTS_PAR_W-1:0]  parity_in
);
   logic [17:0] last_reg = 18'h0;
   wire  [17:0] oe_w = {parity_oe, data_oe};
   wire  [17:0] out_w = {parity_out, data_out};
   // =====
   // undriven bits flip each cycle so a stale value never passes
   wire  [17:0] lvl = m_en ? m_word : (oe_w & out_w) | (~oe_w & ~last_reg);
   assign {parity_in, data_in} = lvl;
   always_ff @(posedge pclk) last_reg <= lvl;
endmodule : fts_bus_model

// File: tb/fts_sram_port_properties.sv
/* Checker for the SRAM port top: driver and apb answer relations.
   Assumes one clock pclk and presetn asynchronous active low. */
`timescale 1ns/1ps
`include "fts_regs.svh"
module fts_sram_port_properties (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`FTS_APB_AW-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   clk_qualify_n,
   input wire logic                   write_request_n,
   input wire logic                   select_low_a,
   input wire logic                   select_high,
   input wire logic                   select_low_b,
   input wire logic                   out_drive_en_n,
   input wire logic [`FTS_DATA_W-1:0] data_out,
   input wire logic [`FTS_DATA_W-1:0] data_oe,
   input wire logic [`FTS_PAR_W-1:0]  parity_out,
   input wire logic [`FTS_PAR_W-1:0]  parity_oe
);
   logic        s1, s2, wr1, rd1, en;
   wire         sel = !select_low_a && !select_low_b && select_high && en;
   wire  [17:0] oe = {parity_oe, data_oe};
   // =====
   // history of enabled edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {s1, s2, wr1, rd1} <= 4'h0;
      end else if (!clk_qualify_n) begin
         {s2, s1} <= {s1, sel};
         {wr1, rd1} <= {sel && !write_request_n, sel && write_request_n};
      end
   end
   // copy of the port enable, kept from apb writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 1'h1;
      end else if (psel && penable && pwrite && paddr == `FTS_OFS_CTRL) begin
         en <= pwdata[`FTS_CTRL_EN_BIT];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_WRITE_HIZ: assert property (
      wr1 |-> oe == 18'h0) else $error("drivers on in write phase");
   AST_DESEL_HIZ: assert property (
      !(s1 && s2) |-> oe == 18'h0) else $error("drivers on near deselect");
   AST_GATE_HIZ: assert property (
      out_drive_en_n |-> oe == 18'h0) else $error("drivers on while gated");
   AST_READ_DRIVE: assert property (
      rd1 && s2 && !out_drive_en_n |-> oe == 18'h3FFFF)
      else $error("read data not driven");
   AST_FREEZE: assert property (
      clk_qualify_n |=> $stable({parity_out, data_out}))
      else $error("output moved on a held clock");
   AST_UNMAPPED: assert property (
      psel && penable && paddr > `FTS_OFS_COUNT |-> pslverr)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (
      psel && penable && paddr[1:0] == 2'h0 && paddr <= `FTS_OFS_COUNT
      |-> !pslverr) else $error("mapped access refused");
   AST_READY: assert property (
      psel && penable |-> pready) else $error("apb wait state seen");
endmodule : fts_sram_port_properties

bind fts_sram_port fts_sram_port_properties fts_sram_port_properties_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .clk_qualify_n, .write_request_n, .select_low_a,
   .select_high, .select_low_b, .out_drive_en_n, .data_out, .data_oe,
   .parity_out, .parity_oe);

// File: tb/fts_sram_port_tb_top.sv
/* Bench for the SRAM port: bursts and random traffic against a model.
   Assumes design, bus model and checker sources are compiled first. */
`timescale 1ns/1ps
`include "fts_regs.svh"
module fts_sram_port_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        clk_qualify_n, write_request_n, advance_or_load, m_en;
   logic        select_low_a, select_high, select_low_b;
   logic        out_drive_en_n, burst_order_strap;
   logic [1:0]  byte_lane_write_n, parity_in, parity_out, parity_oe;
   logic [15:0] data_in, data_out, data_oe;
   logic [17:0] address, m_word, pend_d, pend_m;
   logic [17:0] mem [int];
   int          bad_count, cmp_count, base, cnt, cur, pend_a, hi, nph;
   bit          ctrl_en, s1, ph, pend, mode;

   fts_sram_port fts_sram_port_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .clk_qualify_n, .address, .write_request_n, .byte_lane_write_n,
      .advance_or_load, .select_low_a, .select_high, .select_low_b,
      .out_drive_en_n, .burst_order_strap, .data_in, .data_out,
      .data_oe, .parity_in, .parity_out, .parity_oe);
   fts_bus_model fts_bus_model_i (.pclk, .m_en, .m_word, .data_out,
      .data_oe, .parity_out, .parity_oe, .data_in, .parity_in);

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // =====
   // port cycle: drive, check the open phase, then take the edge
   task automatic op(logic [2:0] sc, bit w, bit a, int ad, bit q);
      logic [1:0] ln;
      bit         on;
      ln = 2'($urandom);
      on = $urandom % 8 == 0;
      {select_low_a, select_low_b, select_high} <= sc;
      {write_request_n, advance_or_load} <= {!w, a && s1};
      {clk_qualify_n, out_drive_en_n, m_en} <= {q, on, pend};
      address <= ad[17:0];
      byte_lane_write_n <= ln;
      m_word <= pend_d;
      @(negedge pclk);
      check("drive", {parity_oe, data_oe}, ph && !on ? 18'h3FFFF : 0);
      if (ph && !on) check("read", {parity_out, data_out}, mem[cur]);
      @(posedge pclk);
      if (!q) begin
         nph += s1;
         if (pend) mem[pend_a] = mem[pend_a] & ~pend_m | pend_d & pend_m;
         pend = 0;
         ph = 0;
         if (sc == 3'h1 && ctrl_en) begin
            cnt = a && s1 ? (cnt + 1) % 4 : 0;
            if (!(a && s1)) base = ad[17:0];
            cur = base & ~3 | (mode ? base ^ cnt : base + cnt) & 3;
            {pend, pend_a, ph} = {w, cur, !w && s1};
            pend_m = {~ln[1], ~ln[0], {8{~ln[1]}}, {8{~ln[0]}}};
            pend_d = 18'($urandom);
         end
         s1 = sc == 3'h1 && ctrl_en;
      end
   endtask : op

   // port is frozen while the apb transfer runs
   task automatic apb(bit w, logic [11:0] a, logic [31:0] d, logic [31:0] e);
      clk_qualify_n <= 1'h1;
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      if (!w) check("prdata", prdata, e);
      check("refused", pslverr, a > `FTS_OFS_COUNT);
      {psel, penable} <= 2'h0;
      if (w && a == `FTS_OFS_CTRL) ctrl_en = d[0];
      @(posedge pclk);
   endtask : apb

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      repeat (4000) @(posedge pclk);
      bad_count++;
      finish_test();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, address, m_word} = '0;
      {write_request_n, byte_lane_write_n, out_drive_en_n} = '1;
      void'($urandom(86));
      for (int md = 0; md < 2; md++) begin
         // =====
         // reset with the burst order strap, then registers
         presetn <= 1'h0;
         burst_order_strap <= md[0];
         {select_low_a, select_low_b, select_high, advance_or_load} <= 4'h0;
         {clk_qualify_n, m_en} <= 2'h0;
         {mode, ctrl_en, s1, ph, pend} = {md[0], 4'h8};
         nph = 0;
         repeat (16) @(posedge pclk);
         presetn <= 1'h1;
         @(posedge pclk);
         apb(0, `FTS_OFS_CTRL, 0, 1);
         apb(0, 12'h010, 0, 0);
         hi = $urandom & 32'h3FFF0;
         // write then read four bursts, random starts, junk address on advance
         for (int k = 0; k < 32; k++) begin
            op(3'h1, k < 16, k % 4 != 0, k % 4 ? $urandom :
               hi + (k & 12) + $urandom % 4, 1'h0);
         end
         for (int k = 0; k < 80; k++) begin
            op($urandom % 5 ? 3'h1 : 3'($urandom), $urandom % 2,
               $urandom % 2, hi + $urandom % 16, $urandom % 6 == 0);
         end
         apb(1, `FTS_OFS_CTRL, 0, 0);
         repeat (3) op(3'h1, 0, 0, hi, 0);
         apb(0, `FTS_OFS_STATUS, 0, {30'h0, mode, 1'h0});
         apb(0, `FTS_OFS_ADDR, 0, cur);
         apb(0, `FTS_OFS_COUNT, 0, nph);
         apb(1, `FTS_OFS_CTRL, 1, 0);
         apb(1, 12'hFF0, 1, 0);
         apb(1, `FTS_OFS_COUNT, 32'h5, 0);
         apb(0, `FTS_OFS_COUNT, 0, 0);
      end
      finish_test();
   end
endmodule : fts_sram_port_tb_top
